/* hw/smt_regs.svh */
// register offsets, field values and timing counts of the sync timing bank
// assumes a 32-bit classic Wishbone slave and a 125 MHz clock
`ifndef SMT_REGS_SVH
`define SMT_REGS_SVH

`define SMT_OUT_MODE      8'h00
`define SMT_OUT_CYCLE     8'h04
`define SMT_OUT_SHIFT     8'h08
`define SMT_OUT_MINCYC    8'h0C
`define SMT_OUT_CALC      8'h10
`define SMT_OUT_CMD       8'h14
`define SMT_OUT_DELAY     8'h18
`define SMT_OUT_MISSED    8'h1C
`define SMT_OUT_OVR       8'h20
`define SMT_OUT_SHORT     8'h24
`define SMT_OUT_FAULT     8'h28
`define SMT_IN_MAXSUB     8'h40
`define SMT_IN_MODE       8'h44
`define SMT_IN_CYCLE      8'h48
`define SMT_IN_SHIFT      8'h4C
`define SMT_IN_SUPP       8'h50
`define SMT_IN_MINCYC     8'h54
`define SMT_IN_CALC       8'h58
`define SMT_IN_CMD        8'h5C
`define SMT_IN_DELAY      8'h60
`define SMT_IN_MISSED     8'h64
`define SMT_IN_OVR        8'h68
`define SMT_IN_SHORT      8'h6C
`define SMT_IN_FAULT      8'h70
`define SMT_IN_SHIFT_MEAS 8'h74

`define SMT_MODE_FREE     16'h0000
`define SMT_MODE_SM       16'h0001
`define SMT_MODE_SYNC0    16'h0002
`define SMT_MODE_SYNC1    16'h0003
`define SMT_MODE_SM2_IN   16'h0022
`define SMT_CMD_STOP      16'h0000
`define SMT_CMD_START     16'h0001
`define SMT_MAX_SUB       8'h20
`define SMT_SUPP_BASE     16'h8007
`define SMT_SHIFT_LOCAL   2'h2
`define SMT_SHIFT_SYNC1   2'h1
`define SMT_CLK_MHZ       32'h0000007D
`define SMT_CLK_NS        (32'h000003E8 / `SMT_CLK_MHZ)
`define SMT_MIN_GAP_NS    32'h000003E8
`define SMT_SAT16         16'hFFFF
`define SMT_SAT32         32'hFFFFFFFF

`endif

/* hw/smt_pkg.sv */
// types shared by the sync timing bank
// assumes smt_regs.svh supplies all numeric constants
package smt_pkg;
    typedef enum logic {SMT_IDLE, SMT_BUSY} smt_cyc_e;

    typedef struct packed {
        logic [31:0] shift;
        logic [31:0] cyc;
        logic [31:0] calc;
        logic [31:0] delay;
    } smt_meas_s;

    typedef struct packed {
        logic [15:0] missed;
        logic [15:0] ovr;
        logic [15:0] short_cnt;
        logic        fault;
    } smt_diag_s;
endpackage : smt_pkg

/* hw/smt_top.sv */
// sync timing bank: one side engine per data direction plus a Wishbone slave
// assumes events are one-cycle pulses synchronous to clk_i
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "smt_regs.svh"

module smt_side
    import smt_pkg::*;
#(
    parameter logic [15:0] SM_B_MODE = 16'hFFFF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] mode_i,
    input  wire logic [31:0] period_i,
    input  wire logic [31:0] shift_i,
    input  wire logic        meas_on_i,
    input  wire logic        meas_clr_i,
    input  wire logic        op_i,
    input  wire logic        sync0_i,
    input  wire logic        sync1_i,
    input  wire logic        sm_a_i,
    input  wire logic        sm_b_i,
    input  wire logic        done_i,
    output logic             act_o,
    output smt_meas_s        meas_o,
    output smt_diag_s        diag_o
);
    smt_cyc_e    st_r,    st_nxt;
    logic [31:0] t_trig_r, t_trig_nxt;
    logic [31:0] t_s0_r,  t_s0_nxt;
    logic [31:0] t_s1_r,  t_s1_nxt;
    logic [31:0] t_loc_r, t_loc_nxt;
    logic        seen_r,  seen_nxt;
    logic        pend_r,  pend_nxt;
    logic        run_r,   run_nxt;
    logic        act_r,   act_nxt;
    smt_meas_s   meas_r,  meas_nxt;
    smt_diag_s   diag_r,  diag_nxt;
    logic        dc;
    logic        trig;
    logic        loc_tick;
    logic        fire;
    logic        missed_ev;
    logic        overrun;
    logic        short_ev;

    function automatic logic [31:0] tadd(input logic [31:0] t);
        tadd = (t > `SMT_SAT32 - `SMT_CLK_NS) ? `SMT_SAT32 : t + `SMT_CLK_NS;
    endfunction : tadd

    function automatic logic [15:0] cinc(input logic [15:0] c);
        cinc = (c == `SMT_SAT16) ? c : c + 16'h0001;
    endfunction : cinc

    function automatic logic [31:0] tmax(input logic [31:0] a,
                                         input logic [31:0] b);
        tmax = (b > a) ? b : a;
    endfunction : tmax

    always_comb begin
        dc = (mode_i == `SMT_MODE_SYNC0) || (mode_i == `SMT_MODE_SYNC1);
        // local timer period only matters in free run
        loc_tick = (mode_i == `SMT_MODE_FREE) && (period_i != 32'h0) &&
                   (tadd(t_loc_r) >= period_i);
        case (mode_i)
            `SMT_MODE_FREE:  trig = loc_tick;
            `SMT_MODE_SM:    trig = sm_a_i;
            `SMT_MODE_SYNC0: trig = sync0_i;
            `SMT_MODE_SYNC1: trig = sync1_i;
            SM_B_MODE:       trig = sm_b_i;
            default:         trig = 1'b0;
        endcase
        fire = dc ? (pend_r && t_s0_r >= shift_i) : trig;
        missed_ev = trig && dc && op_i && !seen_r &&
                    !(sm_a_i || sm_b_i);
        overrun = trig && op_i && (st_r == SMT_BUSY) && !done_i;
        short_ev = sync1_i && dc && (t_s0_r < `SMT_MIN_GAP_NS);
    end

    always_comb begin
        t_loc_nxt  = loc_tick ? 32'h0 : tadd(t_loc_r);
        t_trig_nxt = trig ? 32'h0 : tadd(t_trig_r);
        t_s0_nxt   = sync0_i ? 32'h0 : tadd(t_s0_r);
        t_s1_nxt   = sync1_i ? 32'h0 : tadd(t_s1_r);
        seen_nxt   = sm_a_i || sm_b_i || (seen_r && !trig);
        pend_nxt   = (dc && sync0_i) || (pend_r && !fire);
        act_nxt    = fire;
        st_nxt     = st_r;
        case (st_r)
            SMT_IDLE: if (trig) begin
                st_nxt = SMT_BUSY;
            end
            SMT_BUSY: if (done_i && !trig) begin
                st_nxt = SMT_IDLE;
            end
            default:  st_nxt = SMT_IDLE;
        endcase
        diag_nxt = diag_r;
        if (missed_ev) begin
            diag_nxt.missed = cinc(diag_r.missed);
        end
        if (overrun) begin
            diag_nxt.ovr = cinc(diag_r.ovr);
        end
        if (short_ev) begin
            diag_nxt.short_cnt = cinc(diag_r.short_cnt);
        end
        if (trig) begin
            diag_nxt.fault = dc && (st_r == SMT_BUSY) && !done_i;
        end
        meas_nxt = meas_r;
        run_nxt  = run_r;
        if (meas_clr_i) begin
            meas_nxt = '0;
            run_nxt  = 1'b0;
        end else if (meas_on_i) begin
            if (trig) begin
                run_nxt = 1'b1;
                if (run_r) begin
                    meas_nxt.cyc = tmax(meas_r.cyc, t_trig_r);
                end
            end
            if (done_i && st_r == SMT_BUSY) begin
                meas_nxt.calc = tmax(meas_r.calc, t_trig_r);
                if (dc) begin
                    meas_nxt.delay = tmax(meas_r.delay, t_s1_r);
                    meas_nxt.shift = tmax(meas_r.shift, t_s0_r);
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r     <= SMT_IDLE;
            t_trig_r <= 32'h0;
            t_s0_r   <= 32'h0;
            t_s1_r   <= 32'h0;
            t_loc_r  <= 32'h0;
            seen_r   <= 1'b0;
            pend_r   <= 1'b0;
            run_r    <= 1'b0;
            act_r    <= 1'b0;
            meas_r   <= '0;
            diag_r   <= '0;
        end else if (ce_i) begin
            st_r     <= st_nxt;
            t_trig_r <= t_trig_nxt;
            t_s0_r   <= t_s0_nxt;
            t_s1_r   <= t_s1_nxt;
            t_loc_r  <= t_loc_nxt;
            seen_r   <= seen_nxt;
            pend_r   <= pend_nxt;
            run_r    <= run_nxt;
            act_r    <= act_nxt;
            meas_r   <= meas_nxt;
            diag_r   <= diag_nxt;
        end
    end

    assign act_o  = act_r;
    assign meas_o = meas_r;
    assign diag_o = diag_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    missed_count_a: assert property (ce_i && missed_ev &&
        diag_r.missed != `SMT_SAT16 |=> diag_r.missed == $past(diag_r.missed)
        + 16'h0001) else $error("missed event not counted");
    overrun_count_a: assert property (ce_i && overrun &&
        diag_r.ovr != `SMT_SAT16 |=> diag_r.ovr == $past(diag_r.ovr)
        + 16'h0001) else $error("overrun not counted");
    short_count_a: assert property (ce_i && sync1_i && dc &&
        t_s0_r < `SMT_MIN_GAP_NS && diag_r.short_cnt != `SMT_SAT16 |=>
        diag_r.short_cnt == $past(diag_r.short_cnt) + 16'h0001)
        else $error("short spacing not counted");
    counter_sat_a: assert property (ce_i && diag_r.ovr == `SMT_SAT16
        |=> diag_r.ovr == `SMT_SAT16) else $error("counter wrapped");
    fault_flag_a: assert property (ce_i && trig && !dc
        |=> !diag_r.fault) else $error("fault outside distributed clock");
    clear_max_a: assert property (ce_i && meas_clr_i
        |=> meas_r == '0) else $error("maxima not cleared");
    max_hold_a: assert property (ce_i && !meas_clr_i
        |=> meas_r.calc >= $past(meas_r.calc)) else $error("maximum fell");
    shift_sample_a: assert property (ce_i && dc && sync0_i &&
        shift_i == 32'h0 ##1 ce_i |=> act_r) else $error("sample not fired");
    stop_hold_a: assert property (ce_i && !meas_on_i && !meas_clr_i
        |=> $stable(meas_r)) else $error("measured while stopped");

    busy_cycle_c: cover property (st_r == SMT_BUSY ##[1:50] st_r == SMT_IDLE);
    overrun_c:    cover property (overrun);
    short_c:      cover property (short_ev);
endmodule : smt_side

////////////////////////////////////////////////////////////////////////////////

module smt_top
    import smt_pkg::*;
#(
    parameter logic HAS_OUTPUTS = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        op_state_i,
    input  wire logic        sync0_i,
    input  wire logic        sync1_i,
    input  wire logic        sm2_evt_i,
    input  wire logic        sm3_evt_i,
    input  wire logic        out_done_i,
    input  wire logic        in_done_i,
    output logic             out_apply_o,
    output logic             in_sample_o
);
    logic [15:0] out_mode_r,  out_mode_nxt;
    logic [31:0] out_cycle_r, out_cycle_nxt;
    logic [15:0] out_cmd_r,   out_cmd_nxt;
    logic [15:0] in_mode_r,   in_mode_nxt;
    logic [31:0] in_cycle_r,  in_cycle_nxt;
    logic [31:0] in_shift_r,  in_shift_nxt;
    logic [15:0] in_cmd_r,    in_cmd_nxt;
    logic        ack_r,       ack_nxt;
    logic [31:0] rdat_r,      rdat_nxt;
    logic        out_clr;
    logic        in_clr;
    logic        wr;
    logic [15:0] supp;
    smt_meas_s   om;
    smt_meas_s   im;
    smt_diag_s   od;
    smt_diag_s   id;

    function automatic logic [31:0] wmask(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : wmask

    // bits 5:4 follow whether this build has outputs to drive
    assign supp = `SMT_SUPP_BASE | {10'h0, HAS_OUTPUTS ? `SMT_SHIFT_LOCAL
                  : `SMT_SHIFT_SYNC1, 4'h0};

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: answers one cycle after the request, unmapped reads as zero

    always_comb begin
        wr            = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
        ack_nxt       = wb_cyc_i && wb_stb_i && !ack_r;
        out_mode_nxt  = out_mode_r;
        out_cycle_nxt = out_cycle_r;
        out_cmd_nxt   = out_cmd_r;
        in_mode_nxt   = in_mode_r;
        in_cycle_nxt  = in_cycle_r;
        in_shift_nxt  = in_shift_r;
        in_cmd_nxt    = in_cmd_r;
        if (wr) begin
            case (wb_adr_i)
                `SMT_OUT_MODE:  out_mode_nxt  = 16'(wmask({16'h0, out_mode_r},
                                                wb_dat_i, wb_sel_i));
                `SMT_OUT_CYCLE: out_cycle_nxt = wmask(out_cycle_r, wb_dat_i,
                                                wb_sel_i);
                `SMT_OUT_CMD:   out_cmd_nxt   = 16'(wmask({16'h0, out_cmd_r},
                                                wb_dat_i, wb_sel_i));
                `SMT_IN_MODE:   in_mode_nxt   = 16'(wmask({16'h0, in_mode_r},
                                                wb_dat_i, wb_sel_i));
                `SMT_IN_CYCLE:  in_cycle_nxt  = wmask(in_cycle_r, wb_dat_i,
                                                wb_sel_i);
                `SMT_IN_SHIFT:  in_shift_nxt  = wmask(in_shift_r, wb_dat_i,
                                                wb_sel_i);
                `SMT_IN_CMD:    in_cmd_nxt    = 16'(wmask({16'h0, in_cmd_r},
                                                wb_dat_i, wb_sel_i));
                default:        ;
            endcase
        end
        // a run begins only on the step into start, so rewriting 1 keeps maxima
        out_clr = (out_cmd_nxt == `SMT_CMD_START) &&
                  (out_cmd_r != `SMT_CMD_START);
        in_clr  = (in_cmd_nxt == `SMT_CMD_START) &&
                  (in_cmd_r != `SMT_CMD_START);
        case (wb_adr_i)
            `SMT_OUT_MODE:      rdat_nxt = {16'h0, out_mode_r};
            `SMT_OUT_CYCLE:     rdat_nxt = out_cycle_r;
            `SMT_OUT_SHIFT:     rdat_nxt = om.shift;
            `SMT_OUT_MINCYC:    rdat_nxt = om.cyc;
            `SMT_OUT_CALC:      rdat_nxt = om.calc;
            `SMT_OUT_CMD:       rdat_nxt = {16'h0, out_cmd_r};
            `SMT_OUT_DELAY:     rdat_nxt = om.delay;
            `SMT_OUT_MISSED:    rdat_nxt = {16'h0, od.missed};
            `SMT_OUT_OVR:       rdat_nxt = {16'h0, od.ovr};
            `SMT_OUT_SHORT:     rdat_nxt = {16'h0, od.short_cnt};
            `SMT_OUT_FAULT:     rdat_nxt = {31'h0, od.fault};
            `SMT_IN_MAXSUB:     rdat_nxt = {24'h0, `SMT_MAX_SUB};
            `SMT_IN_MODE:       rdat_nxt = {16'h0, in_mode_r};
            `SMT_IN_CYCLE:      rdat_nxt = in_cycle_r;
            `SMT_IN_SHIFT:      rdat_nxt = in_shift_r;
            `SMT_IN_SUPP:       rdat_nxt = {16'h0, supp};
            `SMT_IN_MINCYC:     rdat_nxt = im.cyc;
            `SMT_IN_CALC:       rdat_nxt = im.calc;
            `SMT_IN_CMD:        rdat_nxt = {16'h0, in_cmd_r};
            `SMT_IN_DELAY:      rdat_nxt = im.delay;
            `SMT_IN_MISSED:     rdat_nxt = {16'h0, id.missed};
            `SMT_IN_OVR:        rdat_nxt = {16'h0, id.ovr};
            `SMT_IN_SHORT:      rdat_nxt = {16'h0, id.short_cnt};
            `SMT_IN_FAULT:      rdat_nxt = {31'h0, id.fault};
            `SMT_IN_SHIFT_MEAS: rdat_nxt = im.shift;
            default:            rdat_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_mode_r  <= `SMT_MODE_FREE;
            out_cycle_r <= 32'h0;
            out_cmd_r   <= `SMT_CMD_STOP;
            in_mode_r   <= `SMT_MODE_FREE;
            in_cycle_r  <= 32'h0;
            in_shift_r  <= 32'h0;
            in_cmd_r    <= `SMT_CMD_STOP;
            ack_r       <= 1'b0;
            rdat_r      <= 32'h0;
        end else if (ce_i) begin
            out_mode_r  <= out_mode_nxt;
            out_cycle_r <= out_cycle_nxt;
            out_cmd_r   <= out_cmd_nxt;
            in_mode_r   <= in_mode_nxt;
            in_cycle_r  <= in_cycle_nxt;
            in_shift_r  <= in_shift_nxt;
            in_cmd_r    <= in_cmd_nxt;
            ack_r       <= ack_nxt;
            rdat_r      <= rdat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    ////////////////////////////////////////////////////////////////////////////
    // side engines; outputs apply at SYNC0 itself, only inputs take a shift

    smt_side #(
        .SM_B_MODE (16'hFFFF)
    ) u_out (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .mode_i     (out_mode_r),
        .period_i   (out_cycle_r),
        .shift_i    (32'h0),
        .meas_on_i  (out_cmd_r == `SMT_CMD_START),
        .meas_clr_i (ce_i && out_clr),
        .op_i       (op_state_i),
        .sync0_i    (sync0_i),
        .sync1_i    (sync1_i),
        .sm_a_i     (sm2_evt_i),
        .sm_b_i     (1'b0),
        .done_i     (out_done_i),
        .act_o      (out_apply_o),
        .meas_o     (om),
        .diag_o     (od)
    );

    smt_side #(
        .SM_B_MODE (`SMT_MODE_SM2_IN)
    ) u_in (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .mode_i     (in_mode_r),
        .period_i   (in_cycle_r),
        .shift_i    (in_shift_r),
        .meas_on_i  (in_cmd_r == `SMT_CMD_START),
        .meas_clr_i (ce_i && in_clr),
        .op_i       (op_state_i),
        .sync0_i    (sync0_i),
        .sync1_i    (sync1_i),
        .sm_a_i     (sm3_evt_i),
        .sm_b_i     (sm2_evt_i),
        .done_i     (in_done_i),
        .act_o      (in_sample_o),
        .meas_o     (im),
        .diag_o     (id)
    );

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    maxsub_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        wb_adr_i == `SMT_IN_MAXSUB |=> wb_dat_o == 32'h00000020)
        else $error("subindex zero wrong");
    supp_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
        wb_adr_i == `SMT_IN_SUPP |=> wb_dat_o[15:0] == supp &&
        wb_dat_o[2:0] == 3'h7 && wb_dat_o[15]) else $error("modes mask wrong");
    start_cmd_c: cover property (@(posedge clk_i) out_clr ##[1:100] om.calc
        != 32'h0);
endmodule : smt_top

/* dv/smt_evt_model.sv */
// partner model: far-side event source of the sync timing bank
// assumes the bench asks for one event at a time through fire()
`timescale 1ns/100ps

module smt_evt_model (
    input  wire logic clk_i,
    output logic      sync0_o,
    output logic      sync1_o,
    output logic      sm2_o,
    output logic      sm3_o,
    output logic      out_done_o,
    output logic      in_done_o
);
    logic [5:0] ev_r = 6'h00;

    assign {in_done_o, out_done_o, sm3_o, sm2_o, sync1_o, sync0_o} = ev_r;

    // one clock wide, launched just after an edge; a second call waits
    // for the next edge, so events never merge into a two-cycle pulse
    task automatic fire(input int unsigned which);
        @(posedge clk_i);
        ev_r <= 6'h01 << which;
        @(posedge clk_i);
        ev_r <= 6'h00;
    endtask : fire
endmodule : smt_evt_model

/* dv/test_smt_top.sv */
// self-checking bench of the sync timing bank
// assumes smt_top with outputs present and the event model beside it
`timescale 1ns/100ps
`include "smt_regs.svh"

module test_smt_top;
    typedef struct {
        logic [31:0] exp;
        bit          nz;
        logic [7:0]  adr;
    } smt_note_s;
    localparam logic [15:0] SUPP = `SMT_SUPP_BASE | 16'h0020;
    localparam logic [7:0]  RA [11] = '{`SMT_IN_MAXSUB, `SMT_IN_SUPP,
        `SMT_OUT_MODE, `SMT_OUT_MINCYC, `SMT_OUT_CALC, `SMT_OUT_CMD,
        `SMT_OUT_DELAY, `SMT_OUT_OVR, `SMT_OUT_SHORT, `SMT_OUT_FAULT, 8'h80};
    localparam logic [31:0] RE [11] = '{32'h20, {16'h0, SUPP}, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    localparam logic [15:0] MODES [5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        s0, s1, e2, e3, od, id;
    logic        ce    = 1'b1;
    logic        op    = 1'b1;
    logic [3:0]  sel   = 4'hF;
    logic        apl, smp;
    int          n_cyc = 0, n_apl = 0, n_smp = 0, t_s0 = 0, t_smp = 0;
    logic [31:0] r;
    smt_note_s   note_q [$];
    int          miscompares = 0;
    int          n_checks = 0;

    always #4 clk_i = ~clk_i;

    smt_evt_model u_evt (.clk_i(clk_i), .sync0_o(s0), .sync1_o(s1),
        .sm2_o(e2), .sm3_o(e3), .out_done_o(od), .in_done_o(id));

    smt_top #(.HAS_OUTPUTS(1'b1)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .op_state_i(op), .sync0_i(s0), .sync1_i(s1),
        .sm2_evt_i(e2), .sm3_evt_i(e3), .out_done_i(od), .in_done_i(id),
        .out_apply_o(apl), .in_sample_o(smp));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            miscompares++;
        end
    endtask : check

    // for a read, d is the expected word; nz asks only for a nonzero word
    // only the watchdog ends a wait for ack
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input bit nz = 1'b0,
                       input logic [3:0] s = 4'hF);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        if (!w) note_q.push_back('{d, nz, a});
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // read data is taken only at the edge where ack is seen
    always @(posedge clk_i) begin
        smt_note_s n;
        if (ack === 1'b1 && we === 1'b0 && note_q.size() > 0) begin
            n = note_q.pop_front();
            check($sformatf("reg %h", n.adr),
                  n.nz ? {31'h0, rdat != 32'h0} : rdat,
                  n.nz ? 32'h1 : n.exp);
        end
    end

    // pulse outputs: counted, and the last SYNC0 and sample edges stamped
    always @(posedge clk_i) begin
        n_cyc++;
        if (s0 === 1'b1) t_s0 = n_cyc;
        if (smp === 1'b1) begin
            t_smp = n_cyc;
            n_smp++;
        end
        if (apl === 1'b1) n_apl++;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h99627BAA));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            bus(1'b0, RA[i], RE[i]);
        end
        $display("test reset_values done");
        foreach (MODES[i]) begin
            bus(1'b1, `SMT_IN_MODE, {16'h0, MODES[i]});
            bus(1'b0, `SMT_IN_MODE, {16'h0, MODES[i]});
        end
        r = $urandom;
        bus(1'b1, `SMT_IN_SHIFT, r);
        bus(1'b0, `SMT_IN_SHIFT, r);
        bus(1'b1, `SMT_OUT_MINCYC, r);
        bus(1'b0, `SMT_OUT_MINCYC, 32'h0);
        bus(1'b1, `SMT_IN_CYCLE, r, 1'b0, 4'h5);
        bus(1'b0, `SMT_IN_CYCLE, r & 32'h00FF00FF);
        $display("test access done");
        bus(1'b1, `SMT_OUT_MODE, 32'h1);
        u_evt.fire(2);
        u_evt.fire(2);
        u_evt.fire(4);
        bus(1'b0, `SMT_OUT_OVR, 32'h1);
        $display("test overrun done");
        bus(1'b1, `SMT_OUT_CMD, 32'h1);
        u_evt.fire(2);
        repeat (20) @(posedge clk_i);
        u_evt.fire(4);
        bus(1'b0, `SMT_OUT_CMD, 32'h1);
        bus(1'b0, `SMT_OUT_CALC, 32'h0, 1'b1);
        bus(1'b1, `SMT_OUT_CMD, 32'h0);
        bus(1'b1, `SMT_OUT_CMD, 32'h1);
        bus(1'b0, `SMT_OUT_CALC, 32'h0);
        $display("test measure done");
        bus(1'b1, `SMT_OUT_MODE, 32'h2);
        u_evt.fire(2);
        u_evt.fire(0);
        repeat (10) @(posedge clk_i);
        u_evt.fire(1);
        u_evt.fire(0);
        bus(1'b0, `SMT_OUT_SHORT, 32'h1);
        bus(1'b0, `SMT_OUT_FAULT, 32'h1);
        u_evt.fire(4);
        u_evt.fire(0);
        bus(1'b0, `SMT_OUT_FAULT, 32'h0);
        repeat (130) @(posedge clk_i);
        u_evt.fire(1);
        bus(1'b0, `SMT_OUT_SHORT, 32'h1);
        bus(1'b0, `SMT_OUT_MISSED, 32'h2);
        $display("test dc_diag done");
        // a frozen enable swallows SYNC0; outside operational missed events and overruns do not count
        ce <= 1'b0;
        u_evt.fire(0);
        ce <= 1'b1;
        op <= 1'b0;
        u_evt.fire(0);
        op <= 1'b1;
        bus(1'b0, `SMT_OUT_OVR, 32'h2);
        bus(1'b0, `SMT_OUT_MISSED, 32'h2);
        bus(1'b0, `SMT_OUT_FAULT, 32'h1);
        $display("test freeze done");
        bus(1'b1, `SMT_IN_SHIFT, 32'h28);
        bus(1'b1, `SMT_IN_MODE, 32'h2);
        u_evt.fire(0);
        repeat (12) @(posedge clk_i);
        // 40 ns is five timer steps, plus one step and the registered pulse
        check("sample delay", t_smp - t_s0, 40 / 8 + 2);
        check("sample count", n_smp, 5);
        check("apply count", n_apl, 8);
        $display("test pulses done");
        results();
    end
endmodule : test_smt_top
